// ==== cgc_clock_ctrl.sv ====
// Clock generator control: divider registers, straps, watchdog recovery, stop
//
// Behaviour
// - Byte 9 bits 6..0 hold the writable seven-bit feedback divider.
// - Byte 10 bits 6..1 hold the writable six-bit reference divider.
// - Byte 10 bit 0 selects host dividers, else ROM dividers.
// - Retuning keeps all same-synth clocks at fixed ratio to processor clock.
// - Byte 10 bit 7 test mode, byte 9 bit 7 test pulse, both reset 0.
// - Byte 11 bits 6,5 read the latched bus/link strap levels.
// - On change with timeout selected, apply frequency then start watchdog.
// - Clearing timeout select to 0000 stops watchdog, new frequency stays.
// - Writing new soft frequency select also starts the watchdog.
// - Expiry pulses system reset low and sets timeout status.
// - Frequency is P times feedback over reference, P from prior code.
// - Straps captured at power-on reset before outputs enable.
// - Outputs stay off until the synthesizer reports lock.
// - Spread applies to synth outputs, not reference, USB or floppy.
// - Spread supports center and down, 0.5% and 1.0%, 33 kHz rate.
// - Halt input stops 33 MHz outputs except free-running and 66 MHz link.
// - Halt sampled on bus clock; outputs stop at next falling edge, low.
// - Four-bit timeout select: 0 off, n gives n seconds.
// - Timeout status set on expiry, cleared when selection cleared.
// - After timeout the frequency reverts to the one before the change.
`timescale 1ns/1ps
module cgc_clock_ctrl
  import cgc_pkg::*;
#(
  parameter int TICKS_PER_SEC = CGC_XTAL_HZ,
  parameter int RESET_PULSE_CYC = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic xtal_tick,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic bus_link_mode_strap_1,
  input wire logic bus_link_mode_strap_0,
  input wire logic [3:0] strap_freq_code,
  input wire logic synth_locked,
  input wire logic bus33_clock_halt_n,
  input wire logic spread_enable,
  input wire logic spread_center,
  input wire logic spread_full,
  output logic [6:0] synth_feedback,
  output logic [5:0] synth_refdiv,
  output logic [31:0] synth_p_const,
  output logic synth_ratio_hold,
  output logic [3:0] freq_code,
  output logic test_mode,
  output logic test_pulse,
  output logic outputs_enable,
  output logic bus_clock_out,
  output logic free_running_bus_clock,
  output logic bus_link_clock,
  output logic spread_on_synth,
  output logic spread_mod_step,
  output logic spread_dir_down,
  output logic [1:0] spread_amount,
  output logic system_reset_out_n
);
  logic [7:0] feedback_q;
  logic [7:0] refdiv_q;
  logic [1:0] strap_q;
  logic [3:0] code_strap_q;
  logic cfg_taken_q;
  logic [4:0] soft_freq_select_q;
  logic [3:0] timeout_select_q;
  logic wd_status_q;
  logic [3:0] active_code_q;
  logic [3:0] prior_code_q;
  logic [6:0] fb_prev_q;
  logic [5:0] rd_prev_q;
  logic ovr_prev_q;
  logic [3:0] sec_cnt_q;
  logic [7:0] rst_cnt_q;
  cgc_wd_e wd_state_q;
  logic [1:0] bus_div_q;
  logic bus_clk_q;
  logic halt_seen_q;
  logic bus_gate_q;
  logic [15:0] ss_cnt_q;
  logic sec_pulse;
  logic div_wr;
  logic soft_freq_select_wr;
  logic wd_clear;
  logic change_req;
  logic [3:0] code_sel;
  logic [4:0] soft_freq_select_prev_q;
  logic expiry;

  assign div_wr = reg_wr && (reg_addr == CGC_OFS_FEEDBACK || reg_addr == CGC_OFS_REFDIV);
  assign soft_freq_select_wr = reg_wr && reg_addr == CGC_OFS_SOFT_FREQ_SELECT && reg_wdata[4:0] != soft_freq_select_q;
  assign wd_clear = reg_wr && reg_addr == CGC_OFS_WDOG && reg_wdata[3:0] == CGC_WD_OFF;
  assign change_req = div_wr || soft_freq_select_wr;
  // Expiry beats a simultaneous clear in both status and sequence
  assign expiry = wd_state_q == CGC_ST_WATCH && sec_pulse && sec_cnt_q == timeout_select_q - 4'h1;

  // Straps and frequency code taken once after reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_taken_q <= 1'b0;
      strap_q <= 2'b00;
      code_strap_q <= CGC_FREQ_CODE_RST;
    end else if (!cfg_taken_q) begin
      cfg_taken_q <= 1'b1;
      strap_q <= {bus_link_mode_strap_1, bus_link_mode_strap_0};
      code_strap_q <= strap_freq_code;
    end
  end

  // Outputs wait for configuration capture and synth lock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outputs_enable <= 1'b0;
    end else begin
      outputs_enable <= cfg_taken_q && synth_locked;
    end
  end

  // Divider registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      feedback_q <= CGC_FEEDBACK_RST;
      refdiv_q <= CGC_REFDIV_RST;
      soft_freq_select_q <= CGC_SOFT_FREQ_SELECT_RST;
    end else if (wd_state_q == CGC_ST_RESET && rst_cnt_q == 8'h00) begin
      refdiv_q[CGC_OVERRIDE_BIT] <= ovr_prev_q;
      feedback_q[6:0] <= fb_prev_q;
      refdiv_q[6:1] <= rd_prev_q;
      soft_freq_select_q <= soft_freq_select_prev_q;
    end else if (reg_wr) begin
      if (reg_addr == CGC_OFS_FEEDBACK) begin
        feedback_q <= reg_wdata;
      end
      if (reg_addr == CGC_OFS_REFDIV) begin
        refdiv_q <= reg_wdata;
      end
      if (reg_addr == CGC_OFS_SOFT_FREQ_SELECT) begin
        soft_freq_select_q <= reg_wdata[4:0];
      end
    end
  end

  // Saved settings for reversion, captured as a change is applied while the watchdog is idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fb_prev_q <= 7'h00;
      rd_prev_q <= 6'h00;
      ovr_prev_q <= 1'b0;
      prior_code_q <= CGC_FREQ_CODE_RST;
      soft_freq_select_prev_q <= CGC_SOFT_FREQ_SELECT_RST;
    end else if (change_req && wd_state_q == CGC_ST_IDLE) begin
      fb_prev_q <= feedback_q[6:0];
      rd_prev_q <= refdiv_q[6:1];
      ovr_prev_q <= refdiv_q[CGC_OVERRIDE_BIT];
      prior_code_q <= active_code_q;
      // Soft code too, else the restored code is lost one edge later
      soft_freq_select_prev_q <= soft_freq_select_q;
    end
  end

  // Code in force; P uses the code standing before divider programming
  assign code_sel = soft_freq_select_q[4] ? soft_freq_select_q[3:0] : code_strap_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_code_q <= CGC_FREQ_CODE_RST;
    end else if (wd_state_q == CGC_ST_RESET && rst_cnt_q == 8'h00) begin
      active_code_q <= prior_code_q;
    end else if (!refdiv_q[CGC_OVERRIDE_BIT]) begin
      active_code_q <= code_sel;
    end
  end

  // Divider source mux; frequency applied before watchdog starts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      synth_feedback <= CGC_ROM_FEEDBACK;
      synth_refdiv <= CGC_ROM_REFDIV;
      freq_code <= CGC_FREQ_CODE_RST;
    end else begin
      synth_feedback <= refdiv_q[CGC_OVERRIDE_BIT] ? feedback_q[6:0] : CGC_ROM_FEEDBACK;
      synth_refdiv <= refdiv_q[CGC_OVERRIDE_BIT] ? refdiv_q[6:1] : CGC_ROM_REFDIV;
      freq_code <= active_code_q;
    end
  end

  // P constant, so Fcpu = P * N / M downstream
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      synth_p_const <= 32'h00000000;
    end else begin
      unique case (active_code_q)
        4'h0: synth_p_const <= 32'h00000000;
        4'h1, 4'h5: synth_p_const <= 32'(CGC_P_MID);
        4'h4: synth_p_const <= 32'(CGC_P_LOW);
        4'h8, 4'h9: synth_p_const <= 32'(CGC_P_LOW_B);
        default: synth_p_const <= 32'(CGC_P_HIGH);
      endcase
    end
  end

  // Bus and link clocks share the synth, so ratios stay locked
  assign synth_ratio_hold = 1'b1;
  assign test_mode = refdiv_q[CGC_TEST_MODE_BIT];
  assign test_pulse = feedback_q[CGC_TEST_PULSE_BIT];

  // Watchdog selection and status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_select_q <= CGC_WD_OFF;
      wd_status_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == CGC_OFS_WDOG) begin
        timeout_select_q <= reg_wdata[3:0];
      end
      // Expiry set beats a simultaneous clear
      if (expiry) begin
        wd_status_q <= 1'b1;
      end else if (wd_clear) begin
        wd_status_q <= 1'b0;
      end
    end
  end

  // Watchdog sequence; no selection means no recovery
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_state_q <= CGC_ST_IDLE;
      sec_cnt_q <= 4'h0;
      rst_cnt_q <= 8'h00;
    end else begin
      unique case (wd_state_q)
        CGC_ST_IDLE: begin
          sec_cnt_q <= 4'h0;
          if (change_req && timeout_select_q != CGC_WD_OFF) begin
            wd_state_q <= CGC_ST_WATCH;
          end
        end
        CGC_ST_WATCH: begin
          if (expiry) begin
            wd_state_q <= CGC_ST_RESET;
            rst_cnt_q <= 8'(RESET_PULSE_CYC - 1);
          end else if (wd_clear) begin
            wd_state_q <= CGC_ST_IDLE;
          end else if (sec_pulse) begin
            sec_cnt_q <= sec_cnt_q + 4'h1;
          end
        end
        CGC_ST_RESET: begin
          if (rst_cnt_q == 8'h00) begin
            wd_state_q <= CGC_ST_IDLE;
          end else begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
          end
        end
        default: wd_state_q <= CGC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_out_n <= 1'b1;
    end else begin
      system_reset_out_n <= wd_state_q != CGC_ST_RESET;
    end
  end

  cgc_second_tick #(
    .TICKS_PER_SEC(TICKS_PER_SEC)
  ) u_second (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .xtal_tick(xtal_tick),
    .restart(wd_state_q != CGC_ST_WATCH),
    .sec_pulse(sec_pulse)
  );

  // Internal bus clock, a divided square wave
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_div_q <= 2'b00;
      bus_clk_q <= 1'b0;
    end else if (outputs_enable) begin
      bus_div_q <= bus_div_q + 2'b01;
      if (bus_div_q == 2'(CGC_BUS_DIV / 2 - 1)) begin
        bus_div_q <= 2'b00;
        bus_clk_q <= ~bus_clk_q;
      end
    end
  end

  // Halt sampled on bus rising edge, gate closes at the falling edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halt_seen_q <= 1'b0;
      bus_gate_q <= 1'b0;
    end else if (bus_div_q == 2'(CGC_BUS_DIV / 2 - 1)) begin
      if (!bus_clk_q) begin
        halt_seen_q <= !bus33_clock_halt_n;
      end else begin
        bus_gate_q <= !halt_seen_q;
      end
    end
  end

  // Link clocks stop only in 33 MHz mode; strap low selects 33 MHz
  assign bus_clock_out = bus_clk_q && bus_gate_q;
  assign free_running_bus_clock = bus_clk_q;
  assign bus_link_clock = strap_q[0] ? bus_clk_q : (bus_clk_q && bus_gate_q);

  // Spread settings; reference, USB and floppy paths never see them
  assign spread_on_synth = spread_enable;
  assign spread_dir_down = !spread_center;
  assign spread_amount = spread_full ? 2'b10 : 2'b01;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ss_cnt_q <= 16'h0000;
      spread_mod_step <= 1'b0;
    end else if (xtal_tick && spread_enable) begin
      spread_mod_step <= ss_cnt_q == 16'(CGC_SS_DIV - 1);
      ss_cnt_q <= (ss_cnt_q == 16'(CGC_SS_DIV - 1)) ? 16'h0000 : ss_cnt_q + 16'h0001;
    end else begin
      spread_mod_step <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    reg_rdata = 8'h00;
    unique case (reg_addr)
      CGC_OFS_FEEDBACK: reg_rdata = feedback_q;
      CGC_OFS_REFDIV: reg_rdata = refdiv_q;
      CGC_OFS_STRAP: reg_rdata = {1'b0, strap_q, 5'h00};
      CGC_OFS_WDOG: reg_rdata = {3'b000, wd_status_q, timeout_select_q};
      CGC_OFS_SOFT_FREQ_SELECT: reg_rdata = {3'b000, soft_freq_select_q};
      default: reg_rdata = 8'h00;
    endcase
  end
endmodule : cgc_clock_ctrl

// ==== cgc_clock_ctrl_assertions.sv ====
// Port checker for the clock generator control
`timescale 1ns/1ps
module cgc_clock_ctrl_assertions
  import cgc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic synth_locked,
  input wire logic bus33_clock_halt_n,
  input wire logic spread_enable,
  input wire logic spread_center,
  input wire logic spread_full,
  input wire logic [6:0] synth_feedback,
  input wire logic [5:0] synth_refdiv,
  input wire logic synth_ratio_hold,
  input wire logic test_mode,
  input wire logic outputs_enable,
  input wire logic bus_clock_out,
  input wire logic spread_dir_down,
  input wire logic [1:0] spread_amount,
  input wire logic system_reset_out_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic wr_ref = reg_wr && reg_addr == CGC_OFS_REFDIV;
  a_host_refdiv: assert property (wr_ref && reg_wdata[0] |-> ##2 synth_refdiv == $past(reg_wdata[6:1], 2))
    else $error("host reference divider not applied");
  a_rom_dividers: assert property (wr_ref && !reg_wdata[0] |-> ##2 synth_refdiv == CGC_ROM_REFDIV && synth_feedback == CGC_ROM_FEEDBACK)
    else $error("stored dividers not applied");
  a_test_mode: assert property (wr_ref |=> test_mode == $past(reg_wdata[7]))
    else $error("test mode bit not held");
  a_strap_zeros: assert property (reg_addr == CGC_OFS_STRAP |-> reg_rdata[7] == 1'b0 && reg_rdata[4:0] == 5'h00)
    else $error("strap byte spare bits not zero");
  a_ratio_hold: assert property (synth_ratio_hold)
    else $error("ratio hold dropped");
  a_lock_gate: assert property (!synth_locked |=> !outputs_enable)
    else $error("outputs enabled without lock");
  a_reset_width: assert property ($fell(system_reset_out_n) |-> !system_reset_out_n [*8])
    else $error("system reset pulse too short");
  a_spread_amount: assert property (spread_enable |-> spread_amount == (spread_full ? 2'b10 : 2'b01))
    else $error("spread amount wrong");
  a_spread_dir: assert property (spread_enable |-> spread_dir_down == !spread_center)
    else $error("spread direction wrong");
  a_halt_stops: assert property ((!bus33_clock_halt_n) [*8] |-> !bus_clock_out)
    else $error("bus clock still running while halted");
  c_expiry: cover property ($fell(system_reset_out_n));
  c_override: cover property (wr_ref && reg_wdata[0]);
  c_halt: cover property ((!bus33_clock_halt_n) [*8]);
endmodule : cgc_clock_ctrl_assertions

bind cgc_clock_ctrl cgc_clock_ctrl_assertions cgc_clock_ctrl_assertions_i (.clk_sys, .rst_n,
  .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .synth_locked, .bus33_clock_halt_n,
  .spread_enable, .spread_center, .spread_full, .synth_feedback, .synth_refdiv,
  .synth_ratio_hold, .test_mode, .outputs_enable, .bus_clock_out, .spread_dir_down,
  .spread_amount, .system_reset_out_n);

// ==== cgc_pkg.sv ====
// Package with register map, field positions and timing for the clock generator control
package cgc_pkg;
  localparam logic [7:0] CGC_OFS_FEEDBACK = 8'h09;
  localparam logic [7:0] CGC_OFS_REFDIV = 8'h0A;
  localparam logic [7:0] CGC_OFS_STRAP = 8'h0B;
  localparam logic [7:0] CGC_OFS_WDOG = 8'h06;
  localparam logic [7:0] CGC_OFS_SOFT_FREQ_SELECT = 8'h05;
  localparam int CGC_TEST_PULSE_BIT = 7;
  localparam int CGC_TEST_MODE_BIT = 7;
  localparam int CGC_OVERRIDE_BIT = 0;
  localparam int CGC_STRAP1_BIT = 6;
  localparam int CGC_STRAP0_BIT = 5;
  localparam int CGC_WD_STATUS_BIT = 4;
  localparam logic [7:0] CGC_FEEDBACK_RST = 8'h00;
  localparam logic [7:0] CGC_REFDIV_RST = 8'h00;
  localparam logic [6:0] CGC_ROM_FEEDBACK = 7'h3C;
  localparam logic [5:0] CGC_ROM_REFDIV = 6'h28;
  localparam logic [4:0] CGC_SOFT_FREQ_SELECT_RST = 5'h00;
  localparam logic [3:0] CGC_WD_OFF = 4'h0;
  localparam logic [3:0] CGC_FREQ_CODE_RST = 4'h7;
  localparam int CGC_XTAL_HZ = 14318180;
  localparam int CGC_SS_RATE_HZ = 33000;
  localparam int CGC_SS_DIV = CGC_XTAL_HZ / CGC_SS_RATE_HZ;
  localparam int CGC_BUS_DIV = 4;
  localparam int CGC_P_LOW = 95996000;
  localparam int CGC_P_LOW_B = 95966000;
  localparam int CGC_P_MID = 127994667;
  localparam int CGC_P_HIGH = 191992000;
  typedef enum logic [1:0] {
    CGC_ST_IDLE = 2'b00,
    CGC_ST_WATCH = 2'b01,
    CGC_ST_RESET = 2'b11
  } cgc_wd_e;
endpackage : cgc_pkg

// ==== cgc_second_tick.sv ====
// One-second tick counted on the crystal-rate enable
`timescale 1ns/1ps
module cgc_second_tick
  import cgc_pkg::*;
#(
  parameter int TICKS_PER_SEC = CGC_XTAL_HZ
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic xtal_tick,
  input wire logic restart,
  output logic sec_pulse
);
  logic [23:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 24'h000000;
      sec_pulse <= 1'b0;
    end else if (restart) begin
      cnt_q <= 24'h000000;
      sec_pulse <= 1'b0;
    end else if (xtal_tick) begin
      if (cnt_q == 24'(TICKS_PER_SEC - 1)) begin
        cnt_q <= 24'h000000;
        sec_pulse <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 24'h000001;
        sec_pulse <= 1'b0;
      end
    end else begin
      sec_pulse <= 1'b0;
    end
  end
endmodule : cgc_second_tick

// ==== cgc_synth_model.sv ====
// Crystal time base and synthesizer lock model
`timescale 1ns/1ps
module cgc_synth_model #(
  parameter int XTAL_DIV = 9,
  parameter int LOCK_CYC = 40
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic xtal_tick,
  output logic synth_locked
);
  int div_q;
  int lock_q;
  // Crystal rate enable, about 125/14.3 cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 0;
      xtal_tick <= 1'b0;
    end else begin
      div_q <= (div_q == XTAL_DIV - 1) ? 0 : div_q + 1;
      xtal_tick <= (div_q == XTAL_DIV - 1);
    end
  end
  // Lock comes late so the output gate is seen closed first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 0;
      synth_locked <= 1'b0;
    end else begin
      lock_q <= (lock_q < LOCK_CYC) ? lock_q + 1 : lock_q;
      synth_locked <= (lock_q == LOCK_CYC);
    end
  end
endmodule : cgc_synth_model

// ==== testbench.sv ====
// Self-checking bench for the clock generator control
`timescale 1ns/1ps
module testbench
  import cgc_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, halt_n = 1'b1;
  logic sp_en = 1'b0, sp_c = 1'b0, sp_f = 1'b0, xtal_tick, synth_locked;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [6:0] fb;
  logic [5:0] rd_m;
  logic [31:0] p_c;
  logic [3:0] fcode;
  logic tmode, tpulse, oen, bus_clk, free_clk, link_clk, sp_on, sp_step, sp_down, hold, sro_n;
  logic [1:0] sp_amt;
  int failures = 0, check_count = 0, cycles = 0, n, low;
  cgc_synth_model cgc_synth_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .xtal_tick(xtal_tick),
    .synth_locked(synth_locked));
  cgc_clock_ctrl #(.TICKS_PER_SEC(10), .RESET_PULSE_CYC(16)) cgc_clock_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .xtal_tick(xtal_tick), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_link_mode_strap_1(1'b1), .bus_link_mode_strap_0(1'b0), .strap_freq_code(4'h7),
    .synth_locked(synth_locked), .bus33_clock_halt_n(halt_n), .spread_enable(sp_en),
    .spread_center(sp_c), .spread_full(sp_f), .synth_feedback(fb), .synth_refdiv(rd_m),
    .synth_p_const(p_c), .synth_ratio_hold(hold), .freq_code(fcode), .test_mode(tmode),
    .test_pulse(tpulse), .outputs_enable(oen), .bus_clock_out(bus_clk),
    .free_running_bus_clock(free_clk), .bus_link_clock(link_clk), .spread_on_synth(sp_on),
    .spread_mod_step(sp_step), .spread_dir_down(sp_down), .spread_amount(sp_amt),
    .system_reset_out_n(sro_n));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Idle edge after each write keeps the strobe single-driven per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Code output lags the write by two edges; look once it has settled
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    @(negedge clk_sys);
    check(32'(reg_rdata), 32'(exp));
  endtask : rd
  task automatic expire(input int min_cyc);
    for (n = 0; n < 600 && sro_n; n++) @(negedge clk_sys);
    check(32'(n >= min_cyc && n < 600), 32'h1);
    for (low = 0; !sro_n && low < 40; low++) @(negedge clk_sys);
    check(32'(low), 32'd16);
    @(posedge clk_sys);
  endtask : expire
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    check(32'(oen), 32'h0);
    check({fb, rd_m, fcode, tmode, tpulse, sro_n, hold}, {7'h3C, 6'h28, 4'h7, 4'h3});
    repeat (60) @(negedge clk_sys);
    check(p_c, 32'd191992000);
    check(32'(oen), 32'h1);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h40);
    rd(8'h06, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h09, 8'h50);
    wr(8'h0A, 8'h65);
    check({fb, rd_m}, {7'h50, 6'h32});
    check(p_c, 32'd191992000);
    rd(8'h0A, 8'h65);
    wr(8'h0B, 8'h00);
    rd(8'h0B, 8'h40);
    wr(8'h0A, 8'hE4);
    check({fb, rd_m, tmode}, {7'h3C, 6'h28, 1'b1});
    wr(8'h0A, 8'h65);
    // Change then cancel before expiry
    wr(8'h06, 8'h01);
    wr(8'h09, 8'hC8);
    check(32'(tpulse), 32'h1);
    repeat (40) @(posedge clk_sys);
    wr(8'h06, 8'h00);
    for (n = 0; n < 200; n++) @(negedge clk_sys) low += !sro_n;
    check(32'(low), 32'h0);
    check(32'(fb), 32'h48);
    @(posedge clk_sys);
    wr(8'h06, 8'h01);
    wr(8'h09, 8'h46);
    check(32'(fb), 32'h46);
    expire(75);
    rd(8'h06, 8'h11);
    check(32'(fb), 32'h48);
    wr(8'h06, 8'h00);
    rd(8'h06, 8'h00);
    // Stored dividers back in force, so the soft code sets P again
    wr(8'h0A, 8'h64);
    wr(8'h06, 8'h02);
    wr(8'h05, 8'h14);
    check({fcode, p_c}, {4'h4, 32'd95996000});
    expire(165);
    check(32'(fcode), 32'h7);
    rd(8'h05, 8'h00);
    wr(8'h06, 8'h00);
    @(posedge clk_sys);
    halt_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    low = 0;
    for (n = 0; n < 8; n++) @(negedge clk_sys) low += free_clk ^ bus_clk ^ link_clk;
    check({bus_clk, link_clk, 1'b1}, {2'b00, low > 0});
    @(posedge clk_sys);
    halt_n <= 1'b1;
    for (n = 0; n < 4; n++) begin
      sp_en <= 1'b1;
      sp_c <= n[0];
      sp_f <= n[1];
      @(negedge clk_sys);
      check({sp_on, sp_down, sp_amt}, {1'b1, !n[0], n[1], !n[1]});
      @(posedge clk_sys);
    end
    // Spread kept on: one modulation step per 33 kHz period
    low = 0;
    for (n = 0; n < 4000; n++) @(negedge clk_sys) low += sp_step;
    check(32'(low), 32'd1);
    test_done();
  end
endmodule : testbench
